// File: hdl/addr_gen_defs.svh
// Constants for the ROM and RAM address generator
`ifndef ADDR_GEN_DEFS_SVH
`define ADDR_GEN_DEFS_SVH

`define AG_PC_W        14
`define AG_RAM_W       10
`define AG_ROM_W       10
`define AG_PC_RST      14'h0000
`define AG_RAM_RST     10'h000
`define AG_NIB_RST     4'h0
`define AG_MEMREG_BASE 10'h040
`define AG_PAGE_HI     13
`define AG_PAGE_LO     8
`define AG_ZP_HI       5
`define AG_FLAG_AB     8
`define AG_FLAG_PORT   9
`define AG_ONE_WORD    14'h0001
`define AG_TWO_WORD    14'h0002

`endif

// File: hdl/addr_gen_pkg.sv
// Types shared by the ROM and RAM address generator
`default_nettype none

package addr_gen_pkg;

    typedef enum logic [3:0] {
        OP_NONE             = 4'h0,
        OP_IND_RAM          = 4'h1,
        OP_DIR_RAM          = 4'h3,
        load_from_memreg_op = 4'h2,
        exchange_memreg_op  = 4'h6,
        long_jump_op        = 4'h7,
        long_branch_op      = 4'h5,
        OP_LONG_CALL        = 4'h4,
        page_branch_op      = 4'hC,
        OP_ZERO_CALL        = 4'hD,
        table_branch_op     = 4'hF,
        OP_TABLE_REF        = 4'hE
    } op_t;

    typedef struct packed {
        logic [1:0] w;
        logic [3:0] x;
        logic [3:0] y;
    } ram_ptr_t;

    typedef struct packed {
        logic [3:0] b;
        logic [3:0] acc;
    } acc_b_t;

    typedef struct packed {
        logic [3:0] output_port_two;
        logic [3:0] output_port_one;
    } port_pair_t;

endpackage

`default_nettype wire

// File: hdl/rom_ram_address_generator.sv
// ROM and RAM address generation for a 4-bit controller core
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_defs.svh"

// Overview of operation
// - Indirect RAM address is W, X, Y joined
// - Direct RAM address is the second word
// - Memory registers are sixteen fixed RAM digits
// - Long jump, branch, call load 14 bits
// - Page branch replaces low eight bits of the advanced counter
// - Page branch at page end lands next page
// - Zero-page call loads six bits, clears rest
// - Table branch target from immediate, A, B
// - Flag bit 8 writes accumulator and B
// - Flag bit 9 writes both port registers
// - Both flags update both pairs together
// - Table reference leaves the counter sequential

module rom_ram_address_generator
    import addr_gen_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire logic                 instr_valid_i,
    input  wire op_t                  op_i,
    input  wire logic [`AG_PC_W-1:0]  imm_i,
    input  wire logic [`AG_RAM_W-1:0] second_word_i,
    input  wire ram_ptr_t             ptr_i,
    input  wire acc_b_t               acc_b_i,
    input  wire logic [`AG_ROM_W-1:0] rom_data_i,
    output logic [`AG_PC_W-1:0]       rom_addr_o,
    output logic [`AG_PC_W-1:0]       pc_o,
    output logic [`AG_RAM_W-1:0]      ram_addr_o,
    output logic                      ram_req_o,
    output acc_b_t                    acc_b_o,
    output logic                      acc_b_we_o,
    output port_pair_t                port_o
);

    // ------------------------------------------------------------
    // Address forming helpers
    // ------------------------------------------------------------
    function automatic logic [`AG_PC_W-1:0] table_addr(
        input logic [3:0] imm4,
        input acc_b_t     ab
    );
        table_addr = {2'b00, imm4, ab.b, ab.acc};
    endfunction

    function automatic logic is_op(
        input logic v,
        input op_t  op,
        input op_t  want
    );
        is_op = v && (op == want);
    endfunction

    logic [`AG_PC_W-1:0]  pc_reg;
    logic [`AG_PC_W-1:0]  pc_next;
    logic [`AG_PC_W-1:0]  seq_pc;
    logic [`AG_PC_W-1:0]  tbl_addr;
    logic [`AG_RAM_W-1:0] ram_addr_reg;
    logic [`AG_RAM_W-1:0] ram_addr_next;
    logic                 ram_req_reg;
    logic                 ram_req_next;
    acc_b_t               acc_b_reg;
    logic                 acc_b_we_reg;
    port_pair_t           port_reg;
    logic                 ref_now;
    logic                 ab_flag;
    logic                 port_flag;

    assign tbl_addr  = table_addr(imm_i[3:0], acc_b_i);
    assign ref_now   = is_op(instr_valid_i, op_i, OP_TABLE_REF);
    assign ab_flag   = rom_data_i[`AG_FLAG_AB];
    assign port_flag = rom_data_i[`AG_FLAG_PORT];

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_comb begin
        if (op_i == OP_DIR_RAM) begin
            seq_pc = pc_reg + `AG_TWO_WORD;
        end else begin
            seq_pc = pc_reg + `AG_ONE_WORD;
        end
    end

    always_comb begin
        pc_next = pc_reg;
        if (instr_valid_i) begin
            unique case (op_i)
                long_jump_op,
                long_branch_op,
                OP_LONG_CALL: begin
                    pc_next = imm_i;
                end
                page_branch_op: begin
                    // Page comes from the advanced counter
                    pc_next = {seq_pc[`AG_PAGE_HI:`AG_PAGE_LO],
                               imm_i[7:0]};
                end
                OP_ZERO_CALL: begin
                    pc_next = {8'h00, imm_i[`AG_ZP_HI:0]};
                end
                table_branch_op: begin
                    pc_next = tbl_addr;
                end
                OP_TABLE_REF: begin
                    pc_next = seq_pc;
                end
                OP_NONE,
                OP_IND_RAM,
                OP_DIR_RAM,
                load_from_memreg_op,
                exchange_memreg_op: begin
                    pc_next = seq_pc;
                end
                default: begin
                    pc_next = seq_pc;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pc_reg <= `AG_PC_RST;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // ------------------------------------------------------------
    // RAM address
    // ------------------------------------------------------------
    always_comb begin
        ram_addr_next = ram_addr_reg;
        ram_req_next  = 1'b0;
        if (instr_valid_i) begin
            unique case (op_i)
                OP_IND_RAM: begin
                    ram_addr_next = ptr_i;
                    ram_req_next  = 1'b1;
                end
                OP_DIR_RAM: begin
                    ram_addr_next = second_word_i;
                    ram_req_next  = 1'b1;
                end
                load_from_memreg_op,
                exchange_memreg_op: begin
                    ram_addr_next = `AG_MEMREG_BASE
                                  | {6'h00, imm_i[3:0]};
                    ram_req_next  = 1'b1;
                end
                default: begin
                    ram_req_next  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ram_addr_reg <= `AG_RAM_RST;
            ram_req_reg  <= 1'b0;
        end else begin
            ram_addr_reg <= ram_addr_next;
            ram_req_reg  <= ram_req_next;
        end
    end

    // ------------------------------------------------------------
    // Table data reference
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            acc_b_reg    <= {`AG_NIB_RST, `AG_NIB_RST};
            acc_b_we_reg <= 1'b0;
        end else begin
            acc_b_we_reg <= ref_now && ab_flag;
            if (ref_now && ab_flag) begin
                acc_b_reg <= rom_data_i[7:0];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            port_reg <= {`AG_NIB_RST, `AG_NIB_RST};
        end else if (ref_now && port_flag) begin
            port_reg <= rom_data_i[7:0];
        end
    end

    assign rom_addr_o = tbl_addr;
    assign pc_o       = pc_reg;
    assign ram_addr_o = ram_addr_reg;
    assign ram_req_o  = ram_req_reg;
    assign acc_b_o    = acc_b_reg;
    assign acc_b_we_o = acc_b_we_reg;
    assign port_o     = port_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    logic [5:0] seq_page;
    logic [9:0] ptr_flat;
    assign seq_page = seq_pc[`AG_PAGE_HI:`AG_PAGE_LO];
    assign ptr_flat = ptr_i;

    ind_ram_addr_a: assert property (
        is_op(instr_valid_i, op_i, OP_IND_RAM)
        |=> ram_req_o && ram_addr_o == $past(ptr_flat))
        else $error("indirect RAM address wrong");

    dir_ram_addr_a: assert property (
        is_op(instr_valid_i, op_i, OP_DIR_RAM)
        |=> ram_addr_o == $past(second_word_i)
            && pc_o == $past(pc_o) + 14'h0002)
        else $error("direct RAM address or skip wrong");

    memreg_window_a: assert property (
        instr_valid_i && (op_i == load_from_memreg_op
                          || op_i == exchange_memreg_op)
        |=> ram_addr_o[9:4] == 6'h04
            && ram_addr_o[3:0] == $past(imm_i[3:0]))
        else $error("memory register address wrong");

    long_load_a: assert property (
        instr_valid_i && (op_i == long_jump_op
                          || op_i == long_branch_op
                          || op_i == OP_LONG_CALL)
        |=> pc_o == $past(imm_i))
        else $error("long transfer target wrong");

    page_branch_a: assert property (
        is_op(instr_valid_i, op_i, page_branch_op)
        |=> pc_o[7:0] == $past(imm_i[7:0])
            && pc_o[13:8] == $past(seq_page))
        else $error("page branch target wrong");

    page_edge_a: assert property (
        is_op(instr_valid_i, op_i, page_branch_op)
        && pc_o[7:0] == 8'hFF && pc_o[13:8] != 6'h3F
        |=> pc_o[13:8] == $past(pc_o[13:8]) + 6'h01)
        else $error("page end branch stayed in page");

    zero_call_a: assert property (
        is_op(instr_valid_i, op_i, OP_ZERO_CALL)
        |=> pc_o[13:6] == 8'h00
            && pc_o[5:0] == $past(imm_i[5:0]))
        else $error("zero page call target wrong");

    table_branch_a: assert property (
        is_op(instr_valid_i, op_i, table_branch_op)
        |=> pc_o == {2'b00, $past(imm_i[3:0]),
                     $past(acc_b_i)})
        else $error("table branch target wrong");

    ab_write_a: assert property (
        ref_now && ab_flag
        |=> acc_b_we_o && acc_b_o == $past(rom_data_i[7:0]))
        else $error("accumulator pair not written");

    ab_hold_a: assert property (
        !(ref_now && ab_flag) |=> !acc_b_we_o && $stable(acc_b_o))
        else $error("accumulator pair changed unasked");

    port_write_a: assert property (
        ref_now && port_flag
        |=> port_o == $past(rom_data_i[7:0]))
        else $error("port registers not written");

    both_write_a: assert property (
        ref_now && ab_flag && port_flag
        |=> port_o == acc_b_o && acc_b_we_o)
        else $error("both flags did not update both");

    ref_pc_a: assert property (
        ref_now |=> pc_o == $past(pc_o) + 14'h0001)
        else $error("table reference moved counter");

    page_edge_c: cover property (
        is_op(instr_valid_i, op_i, page_branch_op)
        && pc_o[7:0] == 8'hFF);

    both_flags_c: cover property (ref_now && ab_flag && port_flag);

    tbl_branch_then_ref_c: cover property (
        is_op(instr_valid_i, op_i, table_branch_op)
        ##2 ref_now);

    memreg_c: cover property (
        is_op(instr_valid_i, op_i, exchange_memreg_op));

endmodule // rom_ram_address_generator

`default_nettype wire

// File: verif/rom_model.sv
// Combinational program ROM model that answers the table address
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_defs.svh"

module rom_model (
    input  wire logic [`AG_PC_W-1:0]  rom_addr_i,
    output logic      [`AG_ROM_W-1:0] rom_data_o
);
    // ------------------------------------------------------------
    // ROM contents
    // ------------------------------------------------------------
    // Flag bits follow address bits 9:8; the data byte is scrambled
    assign rom_data_o = {rom_addr_i[9:8], rom_addr_i[7:0] ^ 8'h5A};
endmodule // rom_model

`default_nettype wire

// File: verif/rom_ram_address_generator_tb.sv
// Self-checking bench for the ROM and RAM address generator
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_defs.svh"

`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end

module rom_ram_address_generator_tb;
    import addr_gen_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clock_i       = 1'b0;
    logic        rst_i         = 1'b1;
    logic        instr_valid_i = 1'b0;
    op_t         op_i          = OP_NONE;
    logic [13:0] imm_i         = 14'h0000;
    logic [9:0]  second_word_i = 10'h000;
    ram_ptr_t    ptr_i         = 10'h000;
    acc_b_t      acc_b_i       = 8'h00;
    logic [9:0]  rom_data_i;
    logic [13:0] rom_addr_o;
    logic [13:0] pc_o;
    logic [9:0]  ram_addr_o;
    logic        ram_req_o;
    acc_b_t      acc_b_o;
    logic        acc_b_we_o;
    port_pair_t  port_o;
    int          errors          = 0;
    int          samples_checked = 0;
    logic [13:0] exp_pc          = 14'h0000;
    logic [7:0]  exp_ab          = 8'h00;
    logic [7:0]  exp_port        = 8'h00;
    logic [7:0]  word;

    rom_ram_address_generator dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .op_i(op_i),
        .imm_i(imm_i), .second_word_i(second_word_i), .ptr_i(ptr_i), .acc_b_i(acc_b_i),
        .rom_data_i(rom_data_i), .rom_addr_o(rom_addr_o), .pc_o(pc_o),
        .ram_addr_o(ram_addr_o), .ram_req_o(ram_req_o), .acc_b_o(acc_b_o),
        .acc_b_we_o(acc_b_we_o), .port_o(port_o)
    );

    rom_model rom_u (
        .rom_addr_i(rom_addr_o),
        .rom_data_o(rom_data_i)
    );

    always #10 clock_i = ~clock_i;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One instruction, taken at the second edge; returns with outputs settled
    task automatic issue(input op_t op, input logic [13:0] imm, input logic [9:0] w,
                         input logic [7:0] ab);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        op_i          <= op;
        imm_i         <= imm;
        second_word_i <= w;
        ptr_i         <= w;
        acc_b_i       <= ab;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask

    task automatic t_ram();
        issue(OP_IND_RAM, 14'h0000, 10'h3A5, 8'h00);
        exp_pc = exp_pc + 14'h0001;
        `CHECK(ram_req_o, 1'b1)
        `CHECK(ram_addr_o, 10'h3A5)
        @(posedge clock_i);
        #1;
        `CHECK(ram_req_o, 1'b0)
        `CHECK(pc_o, exp_pc)
        issue(OP_DIR_RAM, 14'h0000, 10'h2C7, 8'h00);
        exp_pc = exp_pc + 14'h0002;
        `CHECK(ram_addr_o, 10'h2C7)
        `CHECK(pc_o, exp_pc)
        for (int i = 0; i < 4; i++) begin
            issue(i[0] ? exchange_memreg_op : load_from_memreg_op,
                  i[1] ? 14'h3FFF : 14'h3FF0, 10'h3FF, 8'h00);
            exp_pc = exp_pc + 14'h0001;
            `CHECK(ram_req_o, 1'b1)
            `CHECK(ram_addr_o, i[1] ? 10'h04F : 10'h040)
        end
        $display("test ram addressing done");
    endtask

    task automatic t_rom();
        op_t         ops [3] = '{long_jump_op, long_branch_op, OP_LONG_CALL};
        logic [13:0] imms[3] = '{14'h3FFF, 14'h2AAA, 14'h1555};
        for (int i = 0; i < 3; i++) begin
            issue(ops[i], imms[i], 10'h000, 8'h00);
            `CHECK(pc_o, imms[i])
        end
        issue(long_jump_op, 14'h0234, 10'h000, 8'h00);
        issue(page_branch_op, 14'h3F12, 10'h000, 8'h00);
        `CHECK(pc_o, 14'h0212)
        issue(long_jump_op, 14'h05FF, 10'h000, 8'h00);
        issue(page_branch_op, 14'h0034, 10'h000, 8'h00);
        `CHECK(pc_o, 14'h0634)
        issue(long_jump_op, 14'h3FC0, 10'h000, 8'h00);
        issue(OP_ZERO_CALL, 14'h3FFF, 10'h000, 8'h00);
        `CHECK(pc_o, 14'h003F)
        issue(OP_ZERO_CALL, 14'h2A95, 10'h000, 8'h00);
        `CHECK(pc_o, 14'h0015)
        issue(table_branch_op, 14'h3FF5, 10'h000, 8'h3C);
        `CHECK(rom_addr_o, 14'h053C)
        `CHECK(pc_o, 14'h053C)
        exp_pc = 14'h053C;
        $display("test rom addressing done");
    endtask

    task automatic t_tref();
        for (int f = 0; f < 4; f++) begin
            issue(OP_TABLE_REF, 14'h3FF8 | 14'(f), 10'h000, 8'h3C + 8'(f));
            word   = (8'h3C + 8'(f)) ^ 8'h5A;
            exp_pc = exp_pc + 14'h0001;
            if (f[0]) exp_ab = word;
            if (f[1]) exp_port = word;
            `CHECK(acc_b_we_o, f[0])
            `CHECK(acc_b_o, exp_ab)
            `CHECK(port_o, exp_port)
            `CHECK(pc_o, exp_pc)
        end
        $display("test table reference done");
    endtask

    // Reset in mid-run clears every register; the first op after release is taken
    task automatic t_reset();
        @(posedge clock_i);
        rst_i <= 1'b1;
        #1;
        `CHECK(pc_o, 14'h0000)
        `CHECK(ram_addr_o, 10'h000)
        `CHECK(ram_req_o, 1'b0)
        `CHECK(acc_b_o, 8'h00)
        `CHECK(acc_b_we_o, 1'b0)
        `CHECK(port_o, 8'h00)
        @(posedge clock_i);
        rst_i <= 1'b0;
        issue(OP_IND_RAM, 14'h0000, 10'h155, 8'h00);
        `CHECK(pc_o, 14'h0001)
        `CHECK(ram_addr_o, 10'h155)
        $display("test mid-run reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        `CHECK(pc_o, 14'h0000)
        `CHECK(port_o, 8'h00)
        t_ram();
        t_rom();
        t_tref();
        t_reset();
        results();
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        errors++;
        $display("ERROR %0t: run limit reached", $time);
        results();
    end
endmodule // rom_ram_address_generator_tb

`default_nettype wire
